// [src/cpu_addressing_mode_decode.sv]
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Immediate operand is the program byte right after the opcode; immediate-to-memory takes it from the byte after the address.
// - Direct mode takes the data address from the byte after the opcode.
// - Short direct picks one of the registers 80h to 83h from opcode bits.
// - Extended target is low opcode nibble joined with the next byte.
// - Relative branch is one byte and reaches -15 to +16 locations.
// - Top three bits give test, bit 4 direction, low nibble the span.
// - A false relative condition continues with the next instruction.
// - Bit direct: bit number in opcode, byte address in next byte.
// - Bit set or clear copies the old bit value into carry.
// - Bit test branch: three bytes, signed displacement -127 to +128.
// - Indirect uses pointer at 80h or 81h chosen by opcode bit 4.
// - Inherent instructions are one byte, all detail in the opcode.
// - Return stack holds six 12-bit cells filled by calls.
// - Accumulator and working registers are reachable as data bytes.
// - Loads and stores take four cycles, one to three bytes long.
// - Loads and stores set zero, keep carry; immediate-to-memory keeps both.
module cpu_addressing_mode_decode
  import addr_decode_pkg::*;
#(
  parameter logic [7:0] ACC_ADDR = 8'hFF
)(
  input  wire logic        mclk,
  input  wire logic        rstn,
  output logic      [11:0] progAddr,
  input  wire logic [7:0]  progData,
  output logic      [7:0]  dataAddr,
  output logic      [7:0]  dataWrData,
  output logic             dataWe,
  input  wire logic [7:0]  dataRdData,
  output logic      [7:0]  accValue,
  output logic             carryFlag,
  output logic             zeroFlag,
  output logic      [2:0]  stackLevel,
  output logic             fetchCycle
);

  logic [1:0]   rstSync;
  logic         rstSyncN;
  state_type    state;
  state_type    nextState;
  logic [2:0]   cyc;
  logic [11:0]  pc;
  logic [11:0]  instAddr;
  logic [7:0]   ir;
  logic [7:0]   acc;
  logic         carry;
  logic         zero;
  logic [2:0]   sp;
  logic [11:0]  stackMem [STACK_CELLS];
  data_req_type dataReq;
  class_type    fetchCls;
  class_type    cls;
  logic [7:0]   readData;
  logic         relTaken;
  logic [11:0]  relTarget;
  logic         testBit;
  logic         btbTaken;
  logic [11:0]  btbTarget;
  logic [11:0]  stackTop;

  // Release is synchronous so no flop leaves reset on a different edge
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rstSync <= 2'h0;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstSyncN = rstSync[1];

  assign fetchCls = decode(progData);
  assign cls = decode(ir);
  // Accumulator lives in the core but answers at its data address
  assign readData = (dataReq.addr == ACC_ADDR) ? acc : dataRdData;

  always_comb
  begin
    case (progData[7:5])
      3'h0: relTaken = !zero;
      3'h1: relTaken = zero;
      3'h2: relTaken = !carry;
      3'h3: relTaken = carry;
      default: relTaken = 1'b0;
    endcase
  end

  // Backward spans 0 to -15, forward +1 to +16
  assign relTarget = progData[OP_DIR_BIT] ? pc - {8'h00, progData[3:0]}
                                          : pc + 12'h001 + {8'h00, progData[3:0]};
  assign testBit = readData[ir[2:0]];
  assign btbTaken = (testBit == ir[OP_COND_BIT]);
  assign btbTarget = instAddr + 12'h001 + {{4{progData[7]}}, progData};
  assign stackTop = (sp == SP_RESET) ? pc + 12'h001 : stackMem[sp - 3'h1];

  always_comb
  begin
    nextState = S_PAD;
    case (state)
      S_FETCH:
        case (fetchCls)
          long_jump_op, call_op, bit_set_op, bit_clear_op, bit_test_op,
          load_direct_op, store_direct_op, load_immediate_op,
          load_immediate_mem_op: nextState = S_BYTE2;
          load_short_op: nextState = S_DATA;
          load_indirect_op, store_indirect_op: nextState = S_PTR;
          default: nextState = S_PAD;
        endcase
      S_BYTE2:
        case (cls)
          bit_set_op, bit_clear_op, bit_test_op, load_direct_op: nextState = S_DATA;
          load_immediate_mem_op: nextState = S_BYTE3;
          default: nextState = S_PAD;
        endcase
      S_BYTE3: nextState = S_PAD;
      S_PTR: nextState = (cls == load_indirect_op) ? S_DATA : S_PAD;
      S_DATA: nextState = S_PAD;
      S_PAD: nextState = (cyc == budget(cls) - 3'h1) ? S_FETCH : S_PAD;
      default: nextState = S_FETCH;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      state <= S_FETCH;
      cyc <= 3'h0;
    end
    else
    begin
      state <= nextState;
      cyc <= (nextState == S_FETCH) ? 3'h0 : cyc + 3'h1;
    end
  end

  // Program counter and instruction capture
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      pc <= PC_RESET;
      instAddr <= PC_RESET;
      ir <= 8'h00;
    end
    else
      case (state)
        S_FETCH:
        begin
          ir <= progData;
          instAddr <= pc;
          if (fetchCls == rel_branch_op)
            pc <= relTaken ? relTarget : pc + 12'h001;
          else if (fetchCls == return_op)
            pc <= stackTop;
          else
            pc <= pc + 12'h001;
        end
        S_BYTE2:
          if (cls == long_jump_op || cls == call_op)
            pc <= {ir[3:0], progData};
          else
            pc <= pc + 12'h001;
        S_BYTE3: pc <= pc + 12'h001;
        S_DATA:
          if (cls == bit_test_op)
            pc <= btbTaken ? btbTarget : pc + 12'h001;
        default: pc <= pc;
      endcase
  end

  // Data space requests; writes land on the edge after they are issued
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      dataReq <= '0;
    else
    begin
      dataReq.we <= 1'b0;
      case (state)
        S_FETCH:
          case (fetchCls)
            load_short_op: dataReq.addr <= REG_BASE | {6'h00, progData[1:0]};
            store_short_op:
            begin
              dataReq.addr <= REG_BASE | {6'h00, progData[1:0]};
              dataReq.wdata <= acc;
              dataReq.we <= 1'b1;
            end
            load_indirect_op, store_indirect_op:
              dataReq.addr <= progData[OP_PTR_BIT] ? PTR_Y_ADDR : PTR_X_ADDR;
            default: dataReq.addr <= dataReq.addr;
          endcase
        S_BYTE2:
          case (cls)
            bit_set_op, bit_clear_op, bit_test_op, load_immediate_mem_op:
              dataReq.addr <= progData;
            load_direct_op: dataReq.addr <= progData;
            store_direct_op:
            begin
              dataReq.addr <= progData;
              dataReq.wdata <= acc;
              dataReq.we <= 1'b1;
            end
            default: dataReq.addr <= dataReq.addr;
          endcase
        S_BYTE3:
        begin
          dataReq.wdata <= progData;
          dataReq.we <= 1'b1;
        end
        S_PTR:
        begin
          dataReq.addr <= readData;
          if (cls == store_indirect_op)
          begin
            dataReq.wdata <= acc;
            dataReq.we <= 1'b1;
          end
        end
        S_DATA:
          if (cls == bit_set_op || cls == bit_clear_op)
          begin
            dataReq.wdata <= (cls == bit_set_op) ? readData | (8'h01 << ir[2:0])
                                                 : readData & ~(8'h01 << ir[2:0]);
            dataReq.we <= 1'b1;
          end
        default: dataReq.we <= 1'b0;
      endcase
    end
  end

  // Accumulator and flags
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      acc <= ACC_RESET;
      carry <= 1'b0;
      zero <= 1'b0;
    end
    else
    begin
      if (dataReq.we && dataReq.addr == ACC_ADDR)
        acc <= dataReq.wdata;
      case (state)
        S_FETCH:
          if (fetchCls == store_short_op || fetchCls == store_indirect_op)
            zero <= (acc == 8'h00);
        S_BYTE2:
          if (cls == load_immediate_op)
          begin
            acc <= progData;
            zero <= (progData == 8'h00);
          end
          else if (cls == store_direct_op)
            zero <= (acc == 8'h00);
        S_DATA:
          case (cls)
            load_short_op, load_direct_op, load_indirect_op:
            begin
              acc <= readData;
              zero <= (readData == 8'h00);
            end
            bit_set_op, bit_clear_op, bit_test_op: carry <= testBit;
            default: carry <= carry;
          endcase
        default: zero <= zero;
      endcase
    end
  end

  // Return stack; a seventh push overwrites the newest cell
  always_ff @(posedge mclk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      sp <= SP_RESET;
      for (int i = 0; i < STACK_CELLS; i++)
        stackMem[i] <= PC_RESET;
    end
    else if (state == S_BYTE2 && cls == call_op)
    begin
      if (sp == SP_FULL)
        stackMem[STACK_CELLS - 1] <= pc + 12'h001;
      else
      begin
        stackMem[sp] <= pc + 12'h001;
        sp <= sp + 3'h1;
      end
    end
    else if (state == S_FETCH && fetchCls == return_op && sp != SP_RESET)
      sp <= sp - 3'h1;
  end

  assign progAddr = pc;
  assign dataAddr = dataReq.addr;
  assign dataWrData = dataReq.wdata;
  assign dataWe = dataReq.we;
  assign accValue = acc;
  assign carryFlag = carry;
  assign zeroFlag = zero;
  assign stackLevel = sp;
  assign fetchCycle = (state == S_FETCH);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSyncN);

  logic fetchRel;
  logic [11:0] seqNext;
  assign fetchRel = fetchCycle && fetchCls == rel_branch_op;
  assign seqNext = pc + 12'h001;

  property p_immediate;
    fetchCycle ##1 (state == S_BYTE2 && cls == load_immediate_op)
      |=> acc == $past(progData);
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate load wrong");

  property p_direct;
    (state == S_BYTE2 && cls == load_direct_op) |=> dataAddr == $past(progData);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_short;
    (fetchCycle && fetchCls == load_short_op)
      |=> dataAddr >= REG_BASE && dataAddr <= REG_LAST_ADDR;
  endproperty
  a_short: assert property (p_short) else $error("short direct out of range");

  property p_extended;
    (state == S_BYTE2 && cls == long_jump_op)
      |=> progAddr == {$past(ir[3:0]), $past(progData)};
  endproperty
  a_extended: assert property (p_extended) else $error("extended target wrong");

  property p_rel_taken;
    (fetchRel && relTaken) |=> progAddr == $past(relTarget) ##1 fetchCycle;
  endproperty
  a_rel_taken: assert property (p_rel_taken) else $error("relative branch wrong");

  property p_rel_fall;
    (fetchRel && !relTaken) |=> progAddr == $past(seqNext);
  endproperty
  a_rel_fall: assert property (p_rel_fall) else $error("fall through wrong");

  property p_bit_carry;
    (state == S_DATA && (cls == bit_set_op || cls == bit_clear_op))
      |=> carry == $past(testBit) && dataWe && dataWrData[ir[2:0]] == (cls == bit_set_op);
  endproperty
  a_bit_carry: assert property (p_bit_carry) else $error("bit op carry wrong");

  property p_bittest_len;
    (fetchCycle && fetchCls == bit_test_op) |=> !fetchCycle [*4] ##1 fetchCycle;
  endproperty
  a_bittest_len: assert property (p_bittest_len) else $error("bit test length wrong");

  property p_stack;
    sp <= SP_FULL;
  endproperty
  a_stack: assert property (p_stack) else $error("stack level beyond six");

  property p_ldst_len;
    (fetchCycle && (fetchCls inside {load_short_op, store_short_op, load_direct_op,
      store_direct_op, load_immediate_op, load_immediate_mem_op, load_indirect_op,
      store_indirect_op})) |=> !fetchCycle [*3] ##1 fetchCycle;
  endproperty
  a_ldst_len: assert property (p_ldst_len) else $error("load store length wrong");

  property p_ldi_mem_flags;
    (fetchCycle && fetchCls == load_immediate_mem_op)
      |=> ($stable(zero) && $stable(carry)) [*4];
  endproperty
  a_ldi_mem_flags: assert property (p_ldi_mem_flags) else $error("flags changed");

  c_rel_taken: cover property (fetchRel && relTaken);
  c_call: cover property (state == S_BYTE2 && cls == call_op);
  c_btb_taken: cover property (state == S_DATA && cls == bit_test_op && btbTaken);
  c_ldi_mem: cover property (state == S_BYTE3 ##1 dataWe);

endmodule

`default_nettype wire

// [include/addr_decode_pkg.sv]
package addr_decode_pkg;

  localparam int PROG_ADDR_W = 12;
  localparam int DATA_ADDR_W = 8;
  localparam int STACK_CELLS = 6;

  // Working registers and pointers in data space
  localparam logic [7:0] REG_BASE = 8'h80;
  localparam logic [7:0] PTR_X_ADDR = 8'h80;
  localparam logic [7:0] PTR_Y_ADDR = 8'h81;
  localparam logic [7:0] REG_LAST_ADDR = 8'h83;

  // Opcode field positions
  localparam int OP_DIR_BIT = 4;
  localparam int OP_PTR_BIT = 4;
  localparam int OP_COND_BIT = 3;

  // Reset values and the full stack level
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [2:0] SP_FULL = 3'h6;

  // Cycles per instruction, counted from the fetch cycle
  localparam logic [2:0] CYC_LDST = 3'h4;
  localparam logic [2:0] CYC_BRANCH = 3'h2;
  localparam logic [2:0] CYC_BITTEST = 3'h5;
  localparam logic [2:0] CYC_BITOP = 3'h4;
  localparam logic [2:0] CYC_JUMP = 3'h4;
  localparam logic [2:0] CYC_INHERENT = 3'h2;

  typedef enum logic [6:0] {
    S_FETCH = 7'b0000001,
    S_BYTE2 = 7'b0000010,
    S_BYTE3 = 7'b0000100,
    S_PTR   = 7'b0001000,
    S_DATA  = 7'b0010000,
    S_PAD   = 7'b0100000,
    S_SPARE = 7'b1000000
  } state_type;

  typedef enum logic [3:0] {
    rel_branch_op, long_jump_op, call_op, bit_set_op,
    bit_clear_op, bit_test_op, load_short_op, store_short_op,
    load_direct_op, store_direct_op, load_immediate_op, load_immediate_mem_op,
    load_indirect_op, store_indirect_op, nop_op, return_op
  } class_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } data_req_type;

  function automatic class_type decode(input logic [7:0] op);
    class_type c;
    c = nop_op;
    if (!op[7])
      c = rel_branch_op;
    else
      case (op[6:4])
        3'h0: c = long_jump_op;
        3'h1: c = call_op;
        3'h2: c = op[3] ? bit_clear_op : bit_set_op;
        3'h3: c = bit_test_op;
        3'h4:
          case (op[3:2])
            2'h0: c = load_short_op;
            2'h1: c = store_short_op;
            2'h2:
              case (op[1:0])
                2'h0: c = load_direct_op;
                2'h1: c = store_direct_op;
                2'h2: c = load_immediate_op;
                default: c = load_immediate_mem_op;
              endcase
            default: c = (op[1:0] == 2'h1) ? return_op : nop_op;
          endcase
        3'h6, 3'h7:
          case (op[3:0])
            4'h0: c = load_indirect_op;
            4'h1: c = store_indirect_op;
            default: c = nop_op;
          endcase
        default: c = nop_op;
      endcase
    return c;
  endfunction

  function automatic logic [2:0] budget(input class_type c);
    logic [2:0] n;
    n = CYC_INHERENT;
    case (c)
      rel_branch_op: n = CYC_BRANCH;
      long_jump_op, call_op: n = CYC_JUMP;
      bit_set_op, bit_clear_op: n = CYC_BITOP;
      bit_test_op: n = CYC_BITTEST;
      nop_op, return_op: n = CYC_INHERENT;
      default: n = CYC_LDST;
    endcase
    return n;
  endfunction

endpackage

// [dv/code_data_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module code_data_mem (
  input  wire logic        mclk,
  input  wire logic [11:0] progAddr,
  output logic      [7:0]  progData,
  input  wire logic [7:0]  dataAddr,
  input  wire logic [7:0]  dataWrData,
  input  wire logic        dataWe,
  output logic      [7:0]  dataRdData
);
  logic [7:0] rom [0:4095];
  logic [7:0] ram [0:255];

  // Unused code holds a one-byte no-op, so a stray fetch shows as a wrong address
  initial
  begin
    for (int i = 0; i < 4096; i++)
      rom[i] = 8'hCE;
    for (int i = 0; i < 256; i++)
      ram[i] = 8'h00;
  end

  // Both reads are combinational, as the core expects them in the same cycle
  assign progData = rom[progAddr];
  assign dataRdData = ram[dataAddr];

  // Plain always: the bench also presets cells by hierarchy
  always @(posedge mclk)
  begin
    if (dataWe === 1'b1)
      ram[dataAddr] <= dataWrData;
  end
endmodule

`default_nettype wire

// [dv/cpu_addressing_mode_decode_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module cpu_addressing_mode_decode_tb;
  import addr_decode_pkg::*;

  logic        mclk;
  logic        rstn;
  logic [11:0] progAddr;
  logic [7:0]  progData;
  logic [7:0]  dataAddr;
  logic [7:0]  dataWrData;
  logic        dataWe;
  logic [7:0]  dataRdData;
  logic [7:0]  accValue;
  logic        carryFlag;
  logic        zeroFlag;
  logic [2:0]  stackLevel;
  logic        fetchCycle;
  int          num_errors;
  int          n_checks;
  int          wCount;
  int          wSeen;
  logic [7:0]  wAddr;
  logic [7:0]  wData;

  cpu_addressing_mode_decode uut (
    .mclk       (mclk),
    .rstn       (rstn),
    .progAddr   (progAddr),
    .progData   (progData),
    .dataAddr   (dataAddr),
    .dataWrData (dataWrData),
    .dataWe     (dataWe),
    .dataRdData (dataRdData),
    .accValue   (accValue),
    .carryFlag  (carryFlag),
    .zeroFlag   (zeroFlag),
    .stackLevel (stackLevel),
    .fetchCycle (fetchCycle)
  );

  code_data_mem mem (
    .mclk       (mclk),
    .progAddr   (progAddr),
    .progData   (progData),
    .dataAddr   (dataAddr),
    .dataWrData (dataWrData),
    .dataWe     (dataWe),
    .dataRdData (dataRdData)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Record every data write the core makes
  always @(posedge mclk)
  begin
    if (dataWe === 1'b1)
    begin
      wAddr <= dataAddr;
      wData <= dataWrData;
      wCount <= wCount + 1;
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] b);
    mem.rom[a] = b;
  endtask

  // Steps to the next opcode fetch; cyc is the length of the instruction just left
  task automatic next_fetch(input logic [11:0] a, input int cyc);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (fetchCycle !== 1'b1 && n < 20);
    if (fetchCycle !== 1'b1)
    begin
      num_errors++;
      end_sim();
    end
    chk("fetch address", a, progAddr);
    chk("cycle count", 12'(cyc), 12'(n));
  endtask

  task automatic exp_write(input logic [7:0] a, input logic [7:0] d);
    chk("write count", 12'(wSeen + 1), 12'(wCount));
    chk("write address", {4'h0, a}, {4'h0, wAddr});
    chk("write data", {4'h0, d}, {4'h0, wData});
    wSeen = wCount;
  endtask

  task automatic exp_core(input logic [7:0] a, input logic z, input logic c);
    chk("accumulator", {4'h0, a}, {4'h0, accValue});
    chk("zero flag", {11'h0, z}, {11'h0, zeroFlag});
    chk("carry flag", {11'h0, c}, {11'h0, carryFlag});
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    chk("first fetch", 12'h000, progAddr);
    chk("fetch flag", 12'h001, {11'h0, fetchCycle});
    chk("stack level", 12'h000, {9'h0, stackLevel});
  endtask

  task automatic t_load_store();
    next_fetch(12'h001, 4);
    exp_core(8'h00, 1'b1, 1'b0);
    next_fetch(12'h004, 4);
    exp_write(8'h90, 8'h3C);
    exp_core(8'h00, 1'b1, 1'b0);
    next_fetch(12'h006, 4);
    exp_core(8'h5A, 1'b0, 1'b0);
    next_fetch(12'h007, 4);
    exp_write(8'h80, 8'h5A);
    next_fetch(12'h009, 4);
    exp_core(8'h3C, 1'b0, 1'b0);
    next_fetch(12'h00A, 4);
    exp_core(8'h00, 1'b1, 1'b0);
  endtask

  task automatic t_rel_branch();
    next_fetch(12'h00D, 2);
    next_fetch(12'h00E, 2);
  endtask

  task automatic t_indirect();
    next_fetch(12'h00F, 4);
    exp_core(8'h77, 1'b0, 1'b0);
    next_fetch(12'h010, 4);
    exp_write(8'h00, 8'h77);
  endtask

  task automatic t_bit_ops();
    next_fetch(12'h012, 4);
    exp_write(8'h20, 8'h08);
    exp_core(8'h77, 1'b0, 1'b0);
    next_fetch(12'h014, 4);
    exp_write(8'h20, 8'h00);
    exp_core(8'h77, 1'b0, 1'b1);
    next_fetch(12'h015, 4);
    exp_core(8'h00, 1'b1, 1'b1);
    next_fetch(12'h01B, 5);
    exp_core(8'h00, 1'b1, 1'b0);
  endtask

  task automatic t_call_jump();
    next_fetch(12'h040, 4);
    chk("stack level", 12'h001, {9'h0, stackLevel});
    next_fetch(12'h01D, 2);
    chk("stack level", 12'h000, {9'h0, stackLevel});
    next_fetch(12'hFFE, 4);
    next_fetch(12'hFEF, 2);
    chk("write total", 12'(wSeen), 12'(wCount));
  endtask

  task automatic t_acc_tail();
    next_fetch(12'hFF2, 4);
    exp_write(8'hFF, 8'hA5);
    exp_core(8'hA5, 1'b1, 1'b0);
    // Clear the backing cell so the next read can only see the core's copy
    mem.ram[8'hFF] = 8'h00;
    next_fetch(12'hFF4, 4);
    exp_write(8'h30, 8'hA5);
    exp_core(8'hA5, 1'b0, 1'b0);
    next_fetch(12'hFF7, 2);
    next_fetch(12'hFF8, 2);
    next_fetch(12'hFFB, 5);
    exp_core(8'hA5, 1'b0, 1'b1);
    next_fetch(12'hFFD, 4);
    exp_core(8'hA5, 1'b0, 1'b1);
    chk("write total", 12'(wSeen), 12'(wCount));
  endtask

  initial
  begin
    rstn = 1'b0;
    num_errors = 0;
    n_checks = 0;
    wCount = 0;
    wSeen = 0;
    wAddr = 8'h00;
    wData = 8'h00;
    #1;
    // Program image, one instruction per line of the walk
    put(12'h000, 8'hC1);
    put(12'h001, 8'hCB);
    put(12'h002, 8'h90);
    put(12'h003, 8'h3C);
    put(12'h004, 8'hCA);
    put(12'h005, 8'h5A);
    put(12'h006, 8'hC4);
    put(12'h007, 8'hC8);
    put(12'h008, 8'h90);
    put(12'h009, 8'hC1);
    put(12'h00A, 8'h22);
    put(12'h00D, 8'h03);
    put(12'h00E, 8'hE0);
    put(12'h00F, 8'hF1);
    put(12'h010, 8'hA3);
    put(12'h011, 8'h20);
    put(12'h012, 8'hAB);
    put(12'h013, 8'h20);
    put(12'h014, 8'hC2);
    put(12'h015, 8'hB3);
    put(12'h016, 8'h20);
    put(12'h017, 8'h05);
    put(12'h01B, 8'h90);
    put(12'h01C, 8'h40);
    put(12'h040, 8'hCD);
    put(12'h01D, 8'h8F);
    put(12'h01E, 8'hFE);
    put(12'hFFE, 8'h3F);
    put(12'hFEF, 8'hCB);
    put(12'hFF0, 8'hFF);
    put(12'hFF1, 8'hA5);
    put(12'hFF2, 8'hC9);
    put(12'hFF3, 8'h30);
    put(12'hFF4, 8'h42);
    put(12'hFF7, 8'h60);
    put(12'hFF8, 8'hB0);
    put(12'hFF9, 8'h30);
    put(12'hFFA, 8'h10);
    put(12'hFFB, 8'hC8);
    put(12'hFFC, 8'hFF);
    put(12'hFFD, 8'h10);
    mem.ram[8'h5A] = 8'h77;
    do_reset();
    t_load_store();
    t_rel_branch();
    t_indirect();
    t_bit_ops();
    t_call_jump();
    t_acc_tail();
    end_sim();
  end
endmodule

`default_nettype wire
